/* File: pcdaf_pkg.sv */
// Constants and carrier types for the port C/D alternate-function override
// What this block does
// (RULE_01) An active DAC enable forces PC7 to input with its input buffer off; PC6..PC4 only lose their input buffer through their analog disable bits.
// (RULE_02) An active power stage output enable forces PC3, PC2 or PC0 to output, driving the stage signal, and never touches the pull-up.
// (RULE_03) An active timer 1 compare B enable replaces the PC1 output value with the wave while the direction stays with the port bit.
// (RULE_04) Enabling external interrupt 3 forces the PC0 input buffer on, even in sleep, so the level reaches the interrupt logic.
// (RULE_05) An enabled USART receiver forces PD4 to input, and a one in the PD4 latch then switches the pull-up on.
// (RULE_06) An enabled USART transmitter forces PD3 to output carrying the transmit data.
// (RULE_07) Software sets the PD3 direction bit to see the timer 0 compare A wave; no direction is forced for it.
// (RULE_08) Software sets the PD2 direction bit to see the timer 1 compare A wave; no direction is forced for it.
// (RULE_09) An SPI slave forces PD3 to input as slave select and is active only while the pin is low; a master leaves the direction bit in charge.
// (RULE_10) PD4 as SPI clock is forced to input in slave mode, the direction bit rules in master mode, and the latch keeps pull-up control.
// (RULE_11) PD3 as SPI master data out is forced to input in slave mode, the direction bit rules in master mode, and the latch keeps pull-up control.
// (RULE_12) PD2 as SPI master data in is forced to input in master mode, the direction bit rules in slave mode, and the latch keeps pull-up control.
// (RULE_13) A programmed clock-out fuse drives the divided clock on PD1 whatever its latch and direction bits, also throughout reset.
// (RULE_14) Software should set analog comparator inputs as inputs with the pull-up off.
// (RULE_15) With no override active, direction, value and pull-up come from the port registers, the input buffer from sleep_input_off.
package pcdaf_pkg;

    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int PORT_W      = 8;
    localparam int PC_DAC      = 7;
    localparam int PC_AN_LO    = 4;
    localparam int PC_STG23    = 3;
    localparam int PC_STG22    = 2;
    localparam int PC_CMPB     = 1;
    localparam int PC_IRQ3     = 0;
    localparam int PD_RX_SCK   = 4;
    localparam int PD_TX_SS    = 3;
    localparam int PD_CMPA_SPI = 2;
    localparam int PD_CLK_OUT  = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_RST = 8'h00;
    localparam logic       BIT_RST = 1'b0;

    // Port register view of one port
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
    } pcdaf_gpio_type;

    // Resolved controls of one port
    typedef struct packed {
        logic [7:0] pull;
        logic [7:0] dir;
        logic [7:0] val;
        logic [7:0] ibuf;
    } pcdaf_pin_type;

    // Peripheral requests on port C
    typedef struct packed {
        logic       dac_output_enable;
        logic [2:0] analog_in_disable;   // ch10, ch9, ch8
        logic       stage2_out3_enable;
        logic       stage2_out3_signal;
        logic       stage2_out2_enable;
        logic       stage2_out2_signal;
        logic       stage1_out0_enable;
        logic       stage1_out0_signal;
        logic       timer1_cmp_b_out_enable;
        logic       timer1_cmp_b_wave;
        logic       ext_irq3_enable;
    } pcdaf_pc_req_type;

    // Peripheral requests on port D
    typedef struct packed {
        logic rx_enable;
        logic tx_enable;
        logic tx_data;
        logic timer0_cmp_a_out_enable;
        logic timer0_cmp_a_wave;
        logic timer1_cmp_a_out_enable;
        logic timer1_cmp_a_wave;
        logic spi_enable;
        logic spi_master;
        logic spi_sck_out;
        logic spi_mosi_out;
        logic spi_miso_out;
    } pcdaf_pd_req_type;

    // Whole state of the block
    typedef struct packed {
        pcdaf_pin_type pc;
        pcdaf_pin_type pd;
        logic          irq3_level;
        logic          spi_slave_active;
    } pcdaf_state_type;

endpackage

/* File: pcdaf_override.sv */
// Port C and port D alternate-function override logic
`timescale 1ns/1ps
`default_nettype none
module pcdaf_override
    import pcdaf_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire pcdaf_gpio_type   pc_gpio,
    input  wire pcdaf_gpio_type   pd_gpio,
    input  wire logic             pullup_disable,
    input  wire logic             sleep_input_off,
    input  wire pcdaf_pc_req_type pc_req,
    input  wire pcdaf_pd_req_type pd_req,
    input  wire logic             clock_out_fuse,
    input  wire logic             divided_clock_out,
    input  wire logic [7:0]       pc_pad_in,
    input  wire logic [7:0]       pd_pad_in,
    output logic [7:0]            pc_pad_out,
    output logic [7:0]            pc_pad_oe_n,
    output logic [7:0]            pc_pullup_en,
    output logic [7:0]            pc_ibuf_en,
    output logic [7:0]            pd_pad_out,
    output logic [7:0]            pd_pad_oe_n,
    output logic [7:0]            pd_pullup_en,
    output logic [7:0]            pd_ibuf_en,
    output logic                  ext_irq3_source,
    output logic                  spi_slave_active
);

    // ------------------------------------------------------------
    // Port register fallback
    // ------------------------------------------------------------
    pcdaf_pin_type   pc_def;
    pcdaf_pin_type   pd_def;
    pcdaf_state_type s_q;
    pcdaf_state_type s_d;
    logic            spi_slave;
    logic            spi_mst;

    // Per-bit defaults when no override is active
    genvar b;
    generate
        for (b = 0; b < PORT_W; b++) begin : g_def
            assign pc_def.pull[b] = pc_gpio.latch[b] & ~pc_gpio.dir[b] & ~pullup_disable; // RULE_15
            assign pc_def.dir[b]  = pc_gpio.dir[b];    // RULE_15
            assign pc_def.val[b]  = pc_gpio.latch[b];  // RULE_15
            assign pc_def.ibuf[b] = ~sleep_input_off;  // RULE_15
            assign pd_def.pull[b] = pd_gpio.latch[b] & ~pd_gpio.dir[b] & ~pullup_disable; // RULE_15
            assign pd_def.dir[b]  = pd_gpio.dir[b];    // RULE_15
            assign pd_def.val[b]  = pd_gpio.latch[b];  // RULE_15
            assign pd_def.ibuf[b] = ~sleep_input_off;  // RULE_15
        end
    endgenerate

    // SPI role decode
    assign spi_slave = pd_req.spi_enable & ~pd_req.spi_master;
    assign spi_mst   = pd_req.spi_enable & pd_req.spi_master;

    // ------------------------------------------------------------
    // Override resolution
    // ------------------------------------------------------------
    // Next state from defaults and peripheral requests
    always_comb begin
        s_d    = s_q;
        s_d.pc = pc_def;
        s_d.pd = pd_def;

        // PC7 DAC output
        if (pc_req.dac_output_enable) begin
            s_d.pc.dir[PC_DAC]  = 1'b0; // RULE_01
            s_d.pc.ibuf[PC_DAC] = 1'b0; // RULE_01
        end
        // PC6..PC4 analog inputs
        for (int i = 0; i < 3; i++) begin
            if (pc_req.analog_in_disable[i]) begin
                s_d.pc.ibuf[PC_AN_LO + i] = 1'b0; // RULE_01
            end
        end
        // Power stage outputs
        if (pc_req.stage2_out3_enable) begin
            s_d.pc.dir[PC_STG23] = 1'b1;                      // RULE_02
            s_d.pc.val[PC_STG23] = pc_req.stage2_out3_signal; // RULE_02
        end
        if (pc_req.stage2_out2_enable) begin
            s_d.pc.dir[PC_STG22] = 1'b1;                      // RULE_02
            s_d.pc.val[PC_STG22] = pc_req.stage2_out2_signal; // RULE_02
        end
        if (pc_req.stage1_out0_enable) begin
            s_d.pc.dir[PC_IRQ3] = 1'b1;                      // RULE_02
            s_d.pc.val[PC_IRQ3] = pc_req.stage1_out0_signal; // RULE_02
        end
        // PC1 timer 1 compare B, direction untouched
        if (pc_req.timer1_cmp_b_out_enable) begin
            s_d.pc.val[PC_CMPB] = pc_req.timer1_cmp_b_wave; // RULE_03
        end
        // PC0 external interrupt keeps its buffer alive
        if (pc_req.ext_irq3_enable) begin
            s_d.pc.ibuf[PC_IRQ3] = 1'b1; // RULE_04
        end

        // PD4: receiver or SPI slave force input, latch keeps pull-up
        if (pd_req.rx_enable || spi_slave) begin
            s_d.pd.dir[PD_RX_SCK]  = 1'b0;                                      // RULE_05
            s_d.pd.pull[PD_RX_SCK] = pd_gpio.latch[PD_RX_SCK] & ~pullup_disable; // RULE_10
        end else if (spi_mst) begin
            s_d.pd.val[PD_RX_SCK] = pd_req.spi_sck_out; // RULE_10
        end

        // PD3: transmitter wins, then SPI slave, then compare A / MOSI
        if (pd_req.tx_enable) begin
            s_d.pd.dir[PD_TX_SS]  = 1'b1;           // RULE_06
            s_d.pd.val[PD_TX_SS]  = pd_req.tx_data; // RULE_06
            s_d.pd.pull[PD_TX_SS] = 1'b0;
        end else if (spi_slave) begin
            s_d.pd.dir[PD_TX_SS]  = 1'b0;                                      // RULE_09
            s_d.pd.pull[PD_TX_SS] = pd_gpio.latch[PD_TX_SS] & ~pullup_disable; // RULE_11
        end else if (pd_req.timer0_cmp_a_out_enable) begin
            s_d.pd.val[PD_TX_SS] = pd_req.timer0_cmp_a_wave; // RULE_07
        end else if (spi_mst) begin
            s_d.pd.val[PD_TX_SS] = pd_req.spi_mosi_out; // RULE_11
        end

        // PD2: SPI master forces input; slave drives data out by dir bit
        if (spi_mst) begin
            s_d.pd.dir[PD_CMPA_SPI]  = 1'b0; // RULE_12
            s_d.pd.pull[PD_CMPA_SPI] = pd_gpio.latch[PD_CMPA_SPI] & ~pullup_disable; // RULE_12
        end else if (pd_req.timer1_cmp_a_out_enable) begin
            s_d.pd.val[PD_CMPA_SPI] = pd_req.timer1_cmp_a_wave; // RULE_08
        end else if (spi_slave) begin
            s_d.pd.val[PD_CMPA_SPI] = pd_req.spi_miso_out; // RULE_12
        end

        // PD1 clock output owns the pin
        if (clock_out_fuse) begin
            s_d.pd.dir[PD_CLK_OUT]  = 1'b1; // RULE_13
            s_d.pd.pull[PD_CLK_OUT] = 1'b0;
        end

        // Pin levels passed to peripherals, PC0 through its input buffer, PD3 straight from the pad
        s_d.irq3_level       = pc_pad_in[PC_IRQ3] & s_d.pc.ibuf[PC_IRQ3]; // RULE_04
        s_d.spi_slave_active = spi_slave & ~pd_pad_in[PD_TX_SS];         // RULE_09
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.pc               <= '{PIN_RST, PIN_RST, PIN_RST, PIN_RST};
            s_q.pd               <= '{PIN_RST, PIN_RST, PIN_RST, PIN_RST};
            s_q.irq3_level       <= BIT_RST;
            s_q.spi_slave_active <= BIT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    // Port C straight from state
    assign pc_pad_out   = s_q.pc.val;
    assign pc_pad_oe_n  = ~s_q.pc.dir;
    assign pc_pullup_en = s_q.pc.pull;
    assign pc_ibuf_en   = s_q.pc.ibuf;

    // Port D, PD1 bypasses the flops so the clock runs during reset
    always_comb begin
        pd_pad_out  = s_q.pd.val;
        pd_pad_oe_n = ~s_q.pd.dir;
        if (clock_out_fuse) begin
            pd_pad_out[PD_CLK_OUT]  = divided_clock_out; // RULE_13
            pd_pad_oe_n[PD_CLK_OUT] = 1'b0;              // RULE_13
        end
    end
    assign pd_pullup_en     = s_q.pd.pull;
    assign pd_ibuf_en       = s_q.pd.ibuf;
    assign ext_irq3_source  = s_q.irq3_level;
    assign spi_slave_active = s_q.spi_slave_active;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_dac_pin_input: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
        pc_req.dac_output_enable |=> pc_pad_oe_n[PC_DAC] && !pc_ibuf_en[PC_DAC])
        else $error("DAC pin not input with buffer off");

    a_stage_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
        pc_req.stage2_out3_enable |=>
            !pc_pad_oe_n[PC_STG23] && pc_pad_out[PC_STG23] == $past(pc_req.stage2_out3_signal))
        else $error("Stage output not driven on PC3");

    a_stage_no_pull: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
        pc_req.stage1_out0_enable |=> pc_pullup_en[PC_IRQ3] == ($past(pc_gpio.latch[PC_IRQ3])
            && !$past(pc_gpio.dir[PC_IRQ3]) && !$past(pullup_disable)))
        else $error("Pull-up overridden on driven stage pin");

    a_cmpb_dir_kept: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_03
        pc_req.timer1_cmp_b_out_enable |=>
            pc_pad_oe_n[PC_CMPB] == !$past(pc_gpio.dir[PC_CMPB])
            && pc_pad_out[PC_CMPB] == $past(pc_req.timer1_cmp_b_wave))
        else $error("Compare B override wrong on PC1");

    a_irq3_buffer: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
        pc_req.ext_irq3_enable |=> pc_ibuf_en[PC_IRQ3]
            && ext_irq3_source == $past(pc_pad_in[PC_IRQ3]))
        else $error("Interrupt 3 level not passed");

    a_rx_pull: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
        pd_req.rx_enable |=> pd_pad_oe_n[PD_RX_SCK]
            && pd_pullup_en[PD_RX_SCK] == ($past(pd_gpio.latch[PD_RX_SCK]) && !$past(pullup_disable)))
        else $error("Receiver pin not input with latch pull-up");

    a_tx_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
        pd_req.tx_enable |=> !pd_pad_oe_n[PD_TX_SS] && pd_pad_out[PD_TX_SS] == $past(pd_req.tx_data))
        else $error("Transmit pin not driving data");

    a_slave_select: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_09
        spi_slave_active |-> $past(spi_slave) && !$past(pd_pad_in[PD_TX_SS]))
        else $error("SPI slave active without low select");

    a_miso_master: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_12
        spi_mst |=> pd_pad_oe_n[PD_CMPA_SPI])
        else $error("Master data-in pin not input");

    a_clk_out_pin: assert property (@(posedge core_clk) // RULE_13
        clock_out_fuse |-> !pd_pad_oe_n[PD_CLK_OUT] && pd_pad_out[PD_CLK_OUT] == divided_clock_out)
        else $error("Clock not driven on PD1");

    a_sck_slave_in: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_10
        spi_slave |=> pd_pad_oe_n[PD_RX_SCK] && pd_pullup_en[PD_RX_SCK]
            == ($past(pd_gpio.latch[PD_RX_SCK]) && !$past(pullup_disable)))
        else $error("Slave clock pin not input with latch pull-up");

    a_mosi_slave_in: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_11
        (spi_slave && !pd_req.tx_enable) |=> pd_pad_oe_n[PD_TX_SS] && pd_pullup_en[PD_TX_SS]
            == ($past(pd_gpio.latch[PD_TX_SS]) && !$past(pullup_disable)))
        else $error("Slave data-in pin not input with latch pull-up");

    a_analog_ibuf: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
        pc_req.analog_in_disable[0] |=> !pc_ibuf_en[PC_AN_LO])
        else $error("Analog pin input buffer still on");

endmodule
`default_nettype wire

/* File: pcdaf_pad_model.sv */
// Pad model: resolves each pin from device drive, outside drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module pcdaf_pad_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pad_in
);
    logic [7:0] float_q = 8'h55;

    // Undriven pins without pull-up wander every cycle
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Device drive wins, then outside drive, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_drv[i]) begin
                pad_in[i] = ext_val[i];
            end else begin
                pad_in[i] = pullup_en[i] | float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: pcdaf_override_tb.sv */
// Self-checking bench for the port C/D override block
`timescale 1ns/1ps
`default_nettype none
module pcdaf_override_tb
    import pcdaf_pkg::*;
;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    pcdaf_gpio_type   pc_gpio, pd_gpio;
    pcdaf_pc_req_type pc_req;
    pcdaf_pd_req_type pd_req;
    logic             pullup_disable, sleep_input_off, clock_out_fuse, divided_clock_out;
    logic             ext_irq3_source, spi_slave_active, dclk_run;
    logic [7:0]       pc_pad_in, pc_pad_out, pc_pad_oe_n, pc_pullup_en, pc_ibuf_en, pc_ext;
    logic [7:0]       pd_pad_in, pd_pad_out, pd_pad_oe_n, pd_pullup_en, pd_ibuf_en, pd_ext;
    int               err_count = 0;
    int               checks_done = 0;

    pcdaf_override pcdaf_override_i (.core_clk(core_clk), .rst_n(rst_n), .pc_gpio(pc_gpio),
        .pd_gpio(pd_gpio), .pullup_disable(pullup_disable), .sleep_input_off(sleep_input_off),
        .pc_req(pc_req), .pd_req(pd_req), .clock_out_fuse(clock_out_fuse),
        .divided_clock_out(divided_clock_out), .pc_pad_in(pc_pad_in), .pd_pad_in(pd_pad_in),
        .pc_pad_out(pc_pad_out), .pc_pad_oe_n(pc_pad_oe_n), .pc_pullup_en(pc_pullup_en),
        .pc_ibuf_en(pc_ibuf_en), .pd_pad_out(pd_pad_out), .pd_pad_oe_n(pd_pad_oe_n),
        .pd_pullup_en(pd_pullup_en), .pd_ibuf_en(pd_ibuf_en),
        .ext_irq3_source(ext_irq3_source), .spi_slave_active(spi_slave_active));
    pcdaf_pad_model pcdaf_pad_model_c_i (.core_clk(core_clk), .pad_out(pc_pad_out),
        .pad_oe_n(pc_pad_oe_n), .pullup_en(pc_pullup_en), .ext_drv(8'hFF),
        .ext_val(pc_ext), .pad_in(pc_pad_in));
    pcdaf_pad_model pcdaf_pad_model_i (.core_clk(core_clk), .pad_out(pd_pad_out),
        .pad_oe_n(pd_pad_oe_n), .pullup_en(pd_pullup_en), .ext_drv(8'h08),
        .ext_val(pd_ext), .pad_in(pd_pad_in));

    // 125 MHz clock and the divided clock fed to PD1
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (dclk_run) divided_clock_out <= ~divided_clock_out;
    end

    // Masked compare of one pin vector
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g,
                       input logic [7:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e & m, g & m);
        end
    endtask

    // Let n falling edges pass
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog far beyond the length of the tests
    initial begin
        #20000;
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        pc_gpio = '0;
        pd_gpio = '0;
        pc_req = '0;
        pd_req = '0;
        pullup_disable = 1'b0;
        sleep_input_off = 1'b0;
        clock_out_fuse = 1'b0;
        divided_clock_out = 1'b0;
        dclk_run = 1'b0;
        pc_ext = 8'h00;
        pd_ext = 8'h00;
        wait_n(8);
        chk("pc oe_n reset", 8'hFF, pc_pad_oe_n, 8'hFF);
        chk("pd oe_n reset", 8'hFF, pd_pad_oe_n, 8'hFF);
        chk("pd out reset", 8'h00, pd_pad_out | pd_pullup_en | pd_ibuf_en, 8'hFF);
        wait_n(8);
        rst_n = 1'b1;
        // Port registers only: latch first, direction second
        pc_gpio = {8'hA5, 8'h0F};
        pd_gpio = {8'h3C, 8'hF0};
        wait_n(1);
        chk("pc out", 8'hA5, pc_pad_out, 8'hFF);
        chk("pc oe_n", 8'hF0, pc_pad_oe_n, 8'hFF);
        chk("pc pull", 8'hA0, pc_pullup_en, 8'hFF);
        chk("pd ibuf", 8'hFF, pd_ibuf_en, 8'hFF);
        chk("pd pull", 8'h0C, pd_pullup_en, 8'hFF);
        pullup_disable = 1'b1;
        wait_n(1);
        chk("pc pull off", 8'h00, pc_pullup_en, 8'hFF);
        pullup_disable = 1'b0;
        // Port C: DAC, analog disables, stage outputs, compare B
        pc_gpio = {8'h01, 8'h82};
        pc_req = '{1'b1, 3'b101, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        wait_n(1);
        chk("pc oe_n ovr", 8'hF0, pc_pad_oe_n, 8'hFF);
        chk("pc out ovr", 8'h0B, pc_pad_out, 8'hFF);
        chk("pc ibuf ovr", 8'h2F, pc_ibuf_en, 8'hFF);
        chk("pc pull ovr", 8'h01, pc_pullup_en, 8'hFF);
        // Interrupt 3 keeps the PC0 buffer alive in sleep
        pc_gpio = '0;
        pc_req = '0;
        pc_req.ext_irq3_enable = 1'b1;
        sleep_input_off = 1'b1;
        pc_ext = 8'h01;
        wait_n(2);
        chk("pc ibuf irq", 8'h01, pc_ibuf_en, 8'hFF);
        chk("irq3 level", 8'h01, {7'h00, ext_irq3_source}, 8'hFF);
        pc_req.ext_irq3_enable = 1'b0;
        wait_n(2);
        chk("pc ibuf sleep", 8'h00, pc_ibuf_en, 8'hFF);
        chk("irq3 gated", 8'h00, {7'h00, ext_irq3_source}, 8'hFF);
        sleep_input_off = 1'b0;
        // Receiver forces PD4 in, latch keeps the pull-up
        pd_gpio = {8'h10, 8'hFF};
        pd_req.rx_enable = 1'b1;
        wait_n(1);
        chk("pd4 rx", 8'h10, pd_pad_oe_n & pd_pullup_en, 8'h10);
        pd_req.rx_enable = 1'b0;
        // Transmitter forces PD3 out with both data levels
        pd_gpio = '0;
        pd_req.tx_enable = 1'b1;
        for (int d = 0; d < 2; d++) begin
            pd_req.tx_data = d[0];
            wait_n(1);
            chk("pd3 tx out", {4'h0, d[0], 3'h0}, pd_pad_out, 8'h08);
            chk("pd3 tx oe_n", 8'h00, pd_pad_oe_n, 8'h08);
        end
        pd_req = '0;
        // Compare waves need the direction bits set by software
        pd_gpio = {8'h00, 8'h0C};
        pd_req.timer0_cmp_a_out_enable = 1'b1;
        pd_req.timer0_cmp_a_wave = 1'b1;
        pd_req.timer1_cmp_a_out_enable = 1'b1;
        pd_req.timer1_cmp_a_wave = 1'b1;
        wait_n(1);
        chk("pd waves", 8'h0C, pd_pad_out & ~pd_pad_oe_n, 8'h0C);
        pd_gpio = '0;
        wait_n(1);
        chk("pd waves no dir", 8'h0C, pd_pad_oe_n, 8'h0C);
        // SPI slave, selected then deselected through PD3
        pd_req = '0;
        pd_req.spi_enable = 1'b1;
        pd_req.spi_miso_out = 1'b1;
        pd_gpio = {8'h1C, 8'hFF};
        wait_n(2);
        chk("slave active", 8'h01, {7'h00, spi_slave_active}, 8'hFF);
        chk("slave oe_n", 8'h18, pd_pad_oe_n, 8'h1C);
        chk("slave pull", 8'h18, pd_pullup_en, 8'h18);
        chk("slave miso", 8'h04, pd_pad_out, 8'h04);
        pd_ext = 8'h08;
        wait_n(2);
        chk("slave idle", 8'h00, {7'h00, spi_slave_active}, 8'hFF);
        // SPI master
        pd_req.spi_master = 1'b1;
        pd_req.spi_sck_out = 1'b1;
        pd_gpio = {8'h04, 8'h10};
        wait_n(2);
        chk("master oe_n", 8'h0C, pd_pad_oe_n, 8'h1C);
        chk("master sck", 8'h10, pd_pad_out, 8'h10);
        chk("master pull", 8'h04, pd_pullup_en, 8'h04);
        chk("master idle", 8'h00, {7'h00, spi_slave_active}, 8'hFF);
        chk("pd7 comparator", 8'h80, pd_pad_oe_n & ~pd_pullup_en, 8'h80);
        // Clock out on PD1 through a reset and after it
        pd_req = '0;
        pd_gpio = {8'h02, 8'h00};
        clock_out_fuse = 1'b1;
        dclk_run = 1'b1;
        rst_n = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (k == 2) rst_n = 1'b1;
            wait_n(1);
            chk("pd1 clk", {6'h00, divided_clock_out, 1'b0}, pd_pad_out, 8'h02);
            chk("pd1 oe_n", 8'h00, pd_pad_oe_n, 8'h02);
            chk("pd1 pull", 8'h00, pd_pullup_en, 8'h02);
            chk("pd oe_n rst", 8'hFD, pd_pad_oe_n, 8'hFD);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
